// File: logic/iceh_host.v
// configuration-memory serial host: sequencer above the bit engine
// assumes one memory target; scl/sda open-drain resolved outside
// Functional notes
// - device is sole master, drives clock, conditions
// - standard-mode rate, seven-bit target address
// - one dedicated memory target, no arbitration
// - base protocol only, no extensions
// - pointer byte follows address in writes
// - write burst ends with stop after ack
// - pointer loaded by write before reading
// - ack each read byte, nack the last
// - stop then start, else repeated start
`timescale 1ns/1ps
`default_nettype none
`include "iceh_defs.vh"
module iceh_host (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire req_valid,
   input wire req_read,
   input wire req_stop_between,
   input wire [6:0] req_taddr,
   input wire [7:0] req_ptr,
   input wire [7:0] req_len,
   input wire [7:0] wr_data,
   input wire scl_in,
   input wire sda_in,
   output reg req_ready,
   output reg wr_take,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg op_done,
   output reg op_err,
   output reg scl_oe,
   output reg sda_oe,
   output reg scl_out,
   output reg sda_out
);
   localparam [8:0] H_IDLE = 9'h001;
   localparam [8:0] H_START = 9'h002;
   localparam [8:0] H_ADDR = 9'h004;
   localparam [8:0] H_PTR = 9'h008;
   localparam [8:0] H_WDATA = 9'h010;
   localparam [8:0] H_MID = 9'h020;
   localparam [8:0] H_RADDR = 9'h040;
   localparam [8:0] H_RDATA = 9'h080;
   localparam [8:0] H_STOP = 9'h100;
   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   reg [8:0] st_q;
   reg issued_q;
   reg rd_q;
   reg mid_stop_q;
   reg err_q;
   reg [6:0] taddr_q;
   reg [7:0] ptr_q;
   reg [7:0] left_q;
   reg cmd_valid_d;
   reg [2:0] cmd_d;
   reg [7:0] tx_d;
   reg ack_d;
   wire done;
   wire [7:0] rx_byte;
   wire ack_seen;
   wire b_scl_oe;
   wire b_sda_oe;
   wire last = (left_q == 8'h01);
   // pin inputs pass two flops; scl is synchronised but never read, no stretching
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else if (ce) begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
      end
   end
   // command for the bit engine per state
   always @* begin
      // one spare cycle after wr_take lets the source present the next byte
      cmd_valid_d = (st_q != H_IDLE) && !issued_q && !wr_take;
      cmd_d = `ICEH_CMD_WRITE;
      tx_d = 8'hFF;
      ack_d = 1'b1;
      case (st_q)
         H_START: cmd_d = `ICEH_CMD_START;
         H_STOP: cmd_d = `ICEH_CMD_STOP;
         H_ADDR: tx_d = {taddr_q, `ICEH_DIR_WR};
         H_PTR: tx_d = ptr_q;
         H_WDATA: tx_d = wr_data;
         H_MID: cmd_d = mid_stop_q ? `ICEH_CMD_STOP : `ICEH_CMD_START;
         H_RADDR: tx_d = {taddr_q, `ICEH_DIR_RD};
         H_RDATA: begin
            cmd_d = `ICEH_CMD_READ;
            ack_d = ~last;
         end
         default: cmd_valid_d = 1'b0;
      endcase
   end
   // bit engine paced at standard-mode rate
   iceh_bit u_bit (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .cmd_valid(cmd_valid_d),
      .cmd(cmd_d),
      .tx_byte(tx_d),
      .tx_ack(ack_d),
      .sda_in(sda_sync_q[1]),
      .done(done),
      .rx_byte(rx_byte),
      .ack_seen(ack_seen),
      .scl_oe(b_scl_oe),
      .sda_oe(b_sda_oe)
   );
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= H_IDLE;
         issued_q <= 1'b0;
         rd_q <= 1'b0;
         mid_stop_q <= 1'b0;
         err_q <= 1'b0;
         taddr_q <= 7'h00;
         ptr_q <= 8'h00;
         left_q <= 8'h00;
         req_ready <= 1'b0;
         wr_take <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         op_done <= 1'b0;
         op_err <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else if (ce) begin
         scl_oe <= b_scl_oe;
         sda_oe <= b_sda_oe;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         op_done <= 1'b0;
         req_ready <= (st_q == H_IDLE) && !req_valid;
         if (cmd_valid_d)
            issued_q <= 1'b1;
         if (done)
            issued_q <= 1'b0;
         case (st_q)
            H_IDLE: if (req_valid) begin
               taddr_q <= req_taddr;
               ptr_q <= req_ptr;
               left_q <= (req_len == 8'h00) ? 8'h01 : req_len;
               rd_q <= req_read;
               mid_stop_q <= req_stop_between;
               err_q <= 1'b0;
               req_ready <= 1'b0;
               st_q <= H_START;
            end
            H_START: if (done) st_q <= H_ADDR;
            H_ADDR: if (done) begin
               if (!ack_seen) begin
                  err_q <= 1'b1;
                  st_q <= H_STOP;
               end else
                  st_q <= H_PTR;
            end
            H_PTR: if (done) begin
               if (!ack_seen) begin
                  err_q <= 1'b1;
                  st_q <= H_STOP;
               end else
                  st_q <= rd_q ? H_MID : H_WDATA;
            end
            H_WDATA: if (done) begin
               wr_take <= 1'b1;
               left_q <= left_q - 8'h01;
               if (!ack_seen || last) begin
                  err_q <= !ack_seen;
                  st_q <= H_STOP;
               end
            end
            H_MID: if (done) begin
               if (mid_stop_q)
                  mid_stop_q <= 1'b0;
               else
                  st_q <= H_RADDR;
            end
            H_RADDR: if (done) begin
               if (!ack_seen) begin
                  err_q <= 1'b1;
                  st_q <= H_STOP;
               end else
                  st_q <= H_RDATA;
            end
            H_RDATA: if (done) begin
               rd_data <= rx_byte;
               rd_valid <= 1'b1;
               left_q <= left_q - 8'h01;
               if (last)
                  st_q <= H_STOP;
            end
            H_STOP: if (done) begin
               op_done <= 1'b1;
               op_err <= err_q;
               st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: logic/iceh_defs.vh
// constants of the configuration-memory serial host engine
// assumes a 20 MHz core clock; included by iceh_host.v and iceh_bit.v
`ifndef ICEH_DEFS_VH
`define ICEH_DEFS_VH
`define ICEH_CLK_HZ 20000000
`define ICEH_BUS_HZ 100000
// quarter of one bit period in core cycles, rounded up so rate stays below max
`define ICEH_QTR ((`ICEH_CLK_HZ + 4 * `ICEH_BUS_HZ - 1) / (4 * `ICEH_BUS_HZ))
`define ICEH_QTR_W 6
// bit engine commands
`define ICEH_CMD_START 3'h1
`define ICEH_CMD_STOP 3'h2
`define ICEH_CMD_WRITE 3'h3
`define ICEH_CMD_READ 3'h4
`define ICEH_CMD_W 3
`define ICEH_DIR_WR 1'h0
`define ICEH_DIR_RD 1'h1
`endif

// File: logic/iceh_bit.v
// bit-level engine: start, stop, byte write with ack sample, byte read
// assumes open-drain bus with pull-ups; inputs already synchronised
`timescale 1ns/1ps
`default_nettype none
`include "iceh_defs.vh"
module iceh_bit (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire cmd_valid,
   input wire [2:0] cmd,
   input wire [7:0] tx_byte,
   input wire tx_ack,
   input wire sda_in,
   output reg done,
   output reg [7:0] rx_byte,
   output reg ack_seen,
   output reg scl_oe,
   output reg sda_oe
);
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_COND = 4'h2;
   localparam [3:0] S_BIT = 4'h4;
   localparam [3:0] S_END = 4'h8;
   reg [3:0] st_q;
   reg [2:0] cmd_q;
   reg [`ICEH_QTR_W-1:0] tick_q;
   reg [1:0] ph_q;
   reg [3:0] bit_q;
   reg [8:0] sh_q;
   wire tick_end = (tick_q == `ICEH_QTR - 1);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         cmd_q <= 3'h0;
         tick_q <= 6'h00;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 9'h000;
         done <= 1'b0;
         rx_byte <= 8'h00;
         ack_seen <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         tick_q <= tick_end ? 6'h00 : tick_q + 6'h01;
         case (st_q)
            S_IDLE: begin
               tick_q <= 6'h00;
               ph_q <= 2'h0;
               if (cmd_valid) begin
                  cmd_q <= cmd;
                  bit_q <= 4'h0;
                  // tx_ack high means pull the ninth bit low
                  sh_q <= (cmd == `ICEH_CMD_READ) ? {8'hFF, ~tx_ack}
                                                 : {tx_byte, 1'b1};
                  st_q <= (cmd == `ICEH_CMD_START ||
                           cmd == `ICEH_CMD_STOP) ? S_COND : S_BIT;
               end
            end
            S_COND: if (tick_end) begin
               ph_q <= ph_q + 2'h1;
               // start: sda falls while scl high; stop: sda rises
               case (ph_q)
                  2'h0: begin
                     sda_oe <= (cmd_q == `ICEH_CMD_STOP);
                  end
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sda_oe <= (cmd_q == `ICEH_CMD_START);
                  default: begin
                     if (cmd_q == `ICEH_CMD_START)
                        scl_oe <= 1'b1;
                     st_q <= S_END;
                  end
               endcase
            end
            S_BIT: if (tick_end) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  2'h0: sda_oe <= ~sh_q[8];
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sh_q <= {sh_q[7:0], sda_in};
                  default: begin
                     scl_oe <= 1'b1;
                     bit_q <= bit_q + 4'h1;
                     // sda kept past the clock fall: no hold-time race
                     if (bit_q == 4'h8)
                        st_q <= S_END;
                  end
               endcase
            end
            S_END: begin
               done <= 1'b1;
               // byte in sh_q[8:1], ninth bit in sh_q[0]
               rx_byte <= sh_q[8:1];
               ack_seen <= ~sh_q[0];
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: bench/iceh_host_checker.sv
// port checker for the serial host engine
// assumes bind into iceh_host; single clock domain
`timescale 1ns/1ps
`default_nettype none
module iceh_host_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic wr_take,
   input wire logic rd_valid,
   input wire logic op_done,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic scl_out,
   input wire logic sda_out
);
   logic scl_q;
   logic [7:0] run_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the clock level; saturates so idle never wraps
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b0;
         run_q <= 8'hFF;
      end else begin
         scl_q <= scl_oe;
         if (scl_oe != scl_q)
            run_q <= 8'h00;
         else if (run_q != 8'hFF)
            run_q <= run_q + 8'h01;
      end
   end
   half_len_a: assert property (scl_oe != scl_q |-> run_q >= 8'h28)
      else $error("clock level too short");
   out_zero_a: assert property (!scl_out && !sda_out)
      else $error("output level not zero");
   take_busy_a: assert property (
      req_valid && req_ready |=> !req_ready)
      else $error("request not taken");
   idle_free_a: assert property (req_ready |-> !scl_oe && !sda_oe)
      else $error("bus held while idle");
   done_free_a: assert property (op_done |=> !scl_oe && !sda_oe)
      else $error("bus held after done");
   start_first_a: assert property (
      $fell(req_ready) |-> ##[1:300] sda_oe && !scl_oe)
      else $error("no start condition");
   rdv_hold_a: assert property (rd_valid |=> (!req_ready) [*8])
      else $error("idle too soon after read byte");
   wtake_busy_a: assert property (wr_take |-> !req_ready ##1 !op_done)
      else $error("done without stop after byte");
endmodule
`default_nettype wire

// File: bench/iceh_mem_model.sv
// behavioural configuration memory on the far side of the bus
// assumes resolved open-drain levels with pull-ups
`timescale 1ns/1ps
`default_nettype none
module iceh_mem_model #(
   parameter [6:0] TADDR = 7'h50
) (
   input wire logic scl,
   input wire logic sda,
   output logic pull
);
   logic [7:0] mem [0:255];
   logic [7:0] ptr, sh, ob;
   integer n, ph, nrd, nstop, i;
   initial begin
      pull = 1'b0;
      ph = 4;
      n = 0;
      nrd = 0;
      nstop = 0;
      for (i = 0; i < 256; i = i + 1)
         mem[i] = i[7:0] ^ 8'hA5;
   end
   always @(negedge sda) if (scl) begin
      n = 0;
      ph = 0;
      nrd = 0;
   end
   always @(posedge sda) if (scl) begin
      nstop = nstop + 1;
      ph = 4;
   end
   always @(posedge scl) begin
      if (ph == 3 && n == 8 && sda)
         ph = 4;
      if (n < 8)
         sh = {sh[6:0], sda};
      n = n + 1;
   end
   always @(negedge scl) begin
      if (n == 8) begin
         if (ph == 1)
            ptr = sh;
         if (ph == 2) begin
            mem[ptr] = sh;
            ptr = ptr + 8'h01;
         end
         pull = ph < 3 && (ph > 0 || sh[7:1] == TADDR);
         ph = ph == 0 ? (!pull ? 4 : sh[0] ? 3 : 1) : ph == 1 ? 2 : ph;
      end else if (n == 9) begin
         n = 0;
         pull = 1'b0;
         if (ph == 3) begin
            ob = mem[ptr];
            ptr = ptr + 8'h01;
            nrd = nrd + 1;
            pull = !ob[7];
         end
      end else if (ph == 3)
         pull = !ob[7 - n];
   end
endmodule
`default_nettype wire

// File: bench/iceh_host_bench.sv
// self-checking bench for the serial host engine
// assumes checker and memory model compiled before it
`timescale 1ns/1ps
`default_nettype none
module iceh_host_bench;
   logic clk, rst_n, req_valid, req_read, req_stop_between;
   logic [6:0] req_taddr;
   logic [7:0] req_ptr, req_len, wr_data, rd_data;
   logic req_ready, wr_take, rd_valid, op_done, op_err;
   logic scl_oe, sda_oe, scl_out, sda_out, pull;
   integer errors, compares, k, t, s0;
   wire scl_w = ~scl_oe;
   wire sda_w = ~(sda_oe | pull);
   always #25 clk = ~clk;
   iceh_host i_iceh_host (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .req_valid(req_valid), .req_read(req_read),
      .req_stop_between(req_stop_between), .req_taddr(req_taddr),
      .req_ptr(req_ptr), .req_len(req_len), .wr_data(wr_data),
      .scl_in(scl_w), .sda_in(sda_w), .req_ready(req_ready),
      .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
      .op_done(op_done), .op_err(op_err), .scl_oe(scl_oe),
      .sda_oe(sda_oe), .scl_out(scl_out), .sda_out(sda_out));
   iceh_mem_model i_iceh_mem_model (.scl(scl_w), .sda(sda_w), .pull(pull));
   task check(input [7:0] s, input [7:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h want %h", $time, s, e);
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d compares %0d", errors, compares);
         if (errors == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // one full bus operation; written bytes and read bytes count up from e0
   task op(input r, input sb, input [6:0] ta, input [7:0] p, input [7:0] len,
      input [7:0] e0);
      begin
         s0 = i_iceh_mem_model.nstop;
         req_read <= r;
         req_stop_between <= sb;
         req_taddr <= ta;
         req_ptr <= p;
         req_len <= len;
         wr_data <= e0;
         req_valid <= 1'b1;
         @(posedge clk);
         while (req_ready !== 1'b1)
            @(posedge clk);
         req_valid <= 1'b0;
         k = 0;
         t = 0;
         while (op_done !== 1'b1 && t < 30000) begin
            @(posedge clk);
            t = t + 1;
            if (wr_take === 1'b1) begin
               k = k + 1;
               wr_data <= e0 + k[7:0];
            end
            if (rd_valid === 1'b1) begin
               check(rd_data, e0 + k[7:0]);
               k = k + 1;
            end
         end
         if (t == 30000) begin
            errors = errors + 1;
            $display("[ERR] %0t operation timed out", $time);
         end
         @(posedge clk);
         t = i_iceh_mem_model.nstop - s0;
      end
   endtask
   task t_write;
      begin
         op(1'b0, 1'b0, 7'h50, 8'hFE, 8'h03, 8'h30);
         check(k[7:0], 8'h03);
         check(t[7:0], 8'h01);
         check({7'h00, op_err}, 8'h00);
         $display("write burst over pointer wrap done");
      end
   endtask
   task t_read_sr;
      begin
         op(1'b1, 1'b0, 7'h50, 8'hFE, 8'h03, 8'h30);
         check(k[7:0], 8'h03);
         check(i_iceh_mem_model.nrd[7:0], 8'h03);
         check(t[7:0], 8'h01);
         $display("read with repeated start done");
      end
   endtask
   task t_read_p;
      begin
         op(1'b1, 1'b1, 7'h50, 8'h10, 8'h00, 8'hB5);
         check(k[7:0], 8'h01);
         check(i_iceh_mem_model.nrd[7:0], 8'h01);
         check(t[7:0], 8'h02);
         $display("read with stop between done");
      end
   endtask
   task t_nack;
      begin
         op(1'b0, 1'b0, 7'h23, 8'h00, 8'h01, 8'h00);
         check({7'h00, op_err}, 8'h01);
         check(t[7:0], 8'h01);
         $display("absent target refused done");
      end
   endtask
   initial begin
      #2500000;
      errors = errors + 1;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_stop_between = 1'b0;
      req_taddr = 7'h00;
      req_ptr = 8'h00;
      req_len = 8'h00;
      wr_data = 8'h00;
      errors = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_write;
      t_read_sr;
      t_read_p;
      t_nack;
      finish_test;
   end
endmodule
bind iceh_host iceh_host_checker i_iceh_host_checker (.clk(clk),
   .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
   .wr_take(wr_take), .rd_valid(rd_valid), .op_done(op_done),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_out(scl_out), .sda_out(sda_out));
`default_nettype wire
